// *** core/wch_analyzer.v ***
// How it works
// - Eighteen channels: mains and genset phase-neutral, phase-phase voltages and currents.
// - Mains current channels usable only when current transformers sit on the load side.
// - Display buffer holds 100 samples of 13 bits at 4096 samples per second.
// - Display vertical scale follows the captured peak so the trace never clips.
// - Display buffer samples are readable by an external fieldbus master.
// - Display buffer is refreshed with the selected channel twice every second.
// - Navigation button presses step the selected channel through all usable channels.
// - Spectral analysis of selected channel runs twice a second, results published.
// - Analyzer uses its own 1024-sample, 13-bit buffer at 4096 samples per second.
// - Only odd multiples of the fundamental are reported as harmonics.
// - Harmonics reported up to 1800 Hz or order 31, whichever is lower.
// - Graph flag set only for harmonics above two percent.
// - Every reported harmonic carries a level in tenths of a percent.
`timescale 1ns/1ps
`include "wch_map.vh"

module wch_analyzer #(
    parameter SW = 13
) (
    clk,
    rstn,
    sample_tick,
    samples_bus,
    fund_hz,
    btn_next_pin,
    ct_load_side_pin,
    disp_rd_addr,
    disp_rd_data,
    disp_scale,
    sel_ch,
    run_done,
    res_valid,
    res_data,
    res_ready
);
    input wire clk;
    input wire rstn;
    input wire sample_tick;
    input wire [18*SW-1:0] samples_bus;
    input wire [11:0] fund_hz;
    input wire btn_next_pin;
    input wire ct_load_side_pin;
    input wire [6:0] disp_rd_addr;
    output reg [SW-1:0] disp_rd_data;
    output reg [3:0] disp_scale;
    output reg [4:0] sel_ch;
    output reg run_done;
    output wire res_valid;
    output wire [`WCH_RES_W-1:0] res_data;
    input wire res_ready;

    localparam S_IDLE = 3'h0;
    localparam S_CAPT = 3'h1;
    localparam S_CORR = 3'h2;
    localparam S_MAG = 3'h3;
    localparam S_DIV = 3'h4;
    localparam S_EMIT = 3'h5;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [10:0] qcos;
        input [4:0] k;
        begin
            case (k)
                5'h00: qcos = 11'h7ff;
                5'h01: qcos = 11'h7f5;
                5'h02: qcos = 11'h7d8;
                5'h03: qcos = 11'h7a7;
                5'h04: qcos = 11'h763;
                5'h05: qcos = 11'h70d;
                5'h06: qcos = 11'h6a6;
                5'h07: qcos = 11'h62e;
                5'h08: qcos = 11'h5a7;
                5'h09: qcos = 11'h512;
                5'h0a: qcos = 11'h471;
                5'h0b: qcos = 11'h3c5;
                5'h0c: qcos = 11'h30f;
                5'h0d: qcos = 11'h252;
                5'h0e: qcos = 11'h18f;
                5'h0f: qcos = 11'h0c8;
                default: qcos = 11'h000;
            endcase
        end
    endfunction

    // 64-point cosine of a phase, built from a quarter wave
    function signed [11:0] wcos;
        input [5:0] p;
        reg [10:0] m;
        begin
            m = p[4] ? qcos(5'h10 - {1'b0, p[3:0]}) : qcos({1'b0, p[3:0]});
            if (p[5] ^ p[4])
                wcos = -$signed({1'b0, m});
            else
                wcos = $signed({1'b0, m});
        end
    endfunction

    function [35:0] abs36;
        input [35:0] a;
        begin
            abs36 = a[35] ? (~a + 36'h1) : a;
        end
    endfunction

    // Next channel, wrapping and skipping unusable mains currents
    function [4:0] next_ch;
        input [4:0] cur;
        input ct_ok;
        reg [4:0] n;
        begin
            n = (cur >= `WCH_CH_LAST) ? 5'h00 : cur + 5'h01;
            if (!ct_ok && n >= `WCH_CH_MAINS_I_FIRST && n <= `WCH_CH_MAINS_I_LAST)
                n = `WCH_CH_GEN_V_FIRST;
            next_ch = n;
        end
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and button edge
    // ------------------------------------------------------------
    reg btn_s1_reg, btn_s2_reg, btn_prev_reg;
    reg ct_s1_reg, ct_s2_reg;
    wire btn_press = btn_s2_reg && !btn_prev_reg;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            btn_s1_reg <= 1'b0;
            btn_s2_reg <= 1'b0;
            btn_prev_reg <= 1'b0;
            ct_s1_reg <= 1'b0;
            ct_s2_reg <= 1'b0;
        end else begin
            btn_s1_reg <= btn_next_pin;
            btn_s2_reg <= btn_s1_reg;
            btn_prev_reg <= btn_s2_reg;
            ct_s1_reg <= ct_load_side_pin;
            ct_s2_reg <= ct_s1_reg;
        end
    end

    wire sel_bad = !ct_s2_reg && sel_ch >= `WCH_CH_MAINS_I_FIRST &&
        sel_ch <= `WCH_CH_MAINS_I_LAST;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sel_ch <= 5'h00;
        end else if (btn_press || sel_bad) begin
            sel_ch <= next_ch(sel_ch, ct_s2_reg);
        end
    end

    // ------------------------------------------------------------
    // Buffers and refresh pacing
    // ------------------------------------------------------------
    reg [SW-1:0] disp_mem [0:`WCH_DISP_LEN-1];
    reg [SW-1:0] ana_mem [0:`WCH_ANA_LEN-1];
    reg [10:0] refresh_cnt_reg;
    reg [2:0] state_reg;
    reg [4:0] cap_ch_reg;
    reg [9:0] idx_reg;
    reg [12:0] peak_reg;
    reg [3:0] hi_reg;
    reg [23:0] ph_reg;
    reg [35:0] acc_i_reg, acc_q_reg, fund_mag_reg;
    reg [45:0] rem_reg;
    reg [9:0] quo_reg;
    reg [`WCH_RES_W-1:0] push_data_reg;
    reg push_valid_reg;
    wire push_ready;
    wire refresh_due = sample_tick && refresh_cnt_reg == `WCH_REFRESH_TICKS - 1;

    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            refresh_cnt_reg <= 11'h000;
        else if (sample_tick)
            refresh_cnt_reg <= refresh_due ? 11'h000 : refresh_cnt_reg + 11'h001;
    end

    always @(posedge clk) begin
        disp_rd_data <= (disp_rd_addr < `WCH_DISP_LEN) ? disp_mem[disp_rd_addr] : {SW{1'b0}};
    end

    // ------------------------------------------------------------
    // Capture and correlation datapath
    // ------------------------------------------------------------
    wire [SW-1:0] cur_sample = samples_bus[cap_ch_reg*SW +: SW];
    wire [12:0] cur_abs = cur_sample[SW-1] ? (~cur_sample + 13'h1) : cur_sample;
    wire [4:0] order = {hi_reg, 1'b1};
    // Full-width product: high orders overflow twelve bits
    wire [16:0] order_hz = order * fund_hz;
    wire [28:0] step_wide = {order_hz, 12'h000};
    wire signed [SW-1:0] x = ana_mem[idx_reg];
    wire signed [24:0] prod_i = x * wcos(ph_reg[23:18]);
    wire signed [24:0] prod_q = x * wcos(ph_reg[23:18] - 6'h10);
    wire [35:0] ai = abs36(acc_i_reg);
    wire [35:0] aq = abs36(acc_q_reg);
    wire [35:0] mag = (ai > aq) ? ai + {1'b0, aq[35:1]} : aq + {1'b0, ai[35:1]};
    wire in_limit = order_hz <= `WCH_MAX_HARM_HZ && order <= `WCH_MAX_ORDER;
    wire last_hi = hi_reg == `WCH_NUM_ODD - 1;

    integer b;
    reg [3:0] peak_len;
    always @* begin
        peak_len = 4'h0;
        for (b = 0; b < 13; b = b + 1)
            if (peak_reg[b])
                peak_len = b[3:0] + 4'h1;
    end

    always @(posedge clk) begin
        if (state_reg == S_CAPT && sample_tick) begin
            ana_mem[idx_reg] <= cur_sample;
            if (idx_reg < `WCH_DISP_LEN)
                disp_mem[idx_reg[6:0]] <= cur_sample;
        end
    end

    // ------------------------------------------------------------
    // Run sequencer
    // ------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= S_IDLE;
            cap_ch_reg <= 5'h00;
            idx_reg <= 10'h000;
            peak_reg <= 13'h0000;
            disp_scale <= 4'h0;
            hi_reg <= 4'h0;
            ph_reg <= 24'h000000;
            acc_i_reg <= 36'h0;
            acc_q_reg <= 36'h0;
            fund_mag_reg <= 36'h0;
            rem_reg <= 46'h0;
            quo_reg <= 10'h000;
            push_valid_reg <= 1'b0;
            push_data_reg <= {`WCH_RES_W{1'b0}};
            run_done <= 1'b0;
        end else begin
            run_done <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    // A refresh that lands mid-run is skipped, not queued
                    if (refresh_due) begin
                        cap_ch_reg <= sel_ch;
                        idx_reg <= 10'h000;
                        peak_reg <= 13'h0000;
                        state_reg <= S_CAPT;
                    end
                end
                S_CAPT: begin
                    if (sample_tick) begin
                        if (idx_reg < `WCH_DISP_LEN && cur_abs > peak_reg)
                            peak_reg <= cur_abs;
                        if (idx_reg == `WCH_DISP_LEN)
                            disp_scale <= peak_len;
                        idx_reg <= idx_reg + 10'h001;
                        if (idx_reg == `WCH_ANA_LEN - 1) begin
                            hi_reg <= 4'h0;
                            ph_reg <= 24'h000000;
                            acc_i_reg <= 36'h0;
                            acc_q_reg <= 36'h0;
                            state_reg <= S_CORR;
                        end
                    end
                end
                S_CORR: begin
                    acc_i_reg <= acc_i_reg + {{11{prod_i[24]}}, prod_i};
                    acc_q_reg <= acc_q_reg + {{11{prod_q[24]}}, prod_q};
                    ph_reg <= ph_reg + step_wide[23:0];
                    idx_reg <= idx_reg + 10'h001;
                    if (idx_reg == `WCH_ANA_LEN - 1)
                        state_reg <= S_MAG;
                end
                S_MAG: begin
                    if (hi_reg == 4'h0) begin
                        fund_mag_reg <= mag;
                        state_reg <= S_EMIT;
                    end else if (in_limit && fund_mag_reg != 36'h0) begin
                        rem_reg <= mag * `WCH_PCT_SCALE;
                        quo_reg <= 10'h000;
                        state_reg <= S_DIV;
                    end else begin
                        state_reg <= S_EMIT;
                    end
                end
                S_DIV: begin
                    // Slow division by subtraction; time per run is ample
                    if (rem_reg >= {10'h000, fund_mag_reg} && quo_reg != `WCH_PCT_MAX) begin
                        rem_reg <= rem_reg - {10'h000, fund_mag_reg};
                        quo_reg <= quo_reg + 10'h001;
                    end else begin
                        push_valid_reg <= 1'b1;
                        push_data_reg <= {cap_ch_reg, order, quo_reg > `WCH_GRAPH_MIN,
                            quo_reg};
                        state_reg <= S_EMIT;
                    end
                end
                default: begin
                    // Stalls here while the result buffer is full
                    if (push_valid_reg && push_ready)
                        push_valid_reg <= 1'b0;
                    if (!push_valid_reg || push_ready) begin
                        ph_reg <= 24'h000000;
                        acc_i_reg <= 36'h0;
                        acc_q_reg <= 36'h0;
                        idx_reg <= 10'h000;
                        hi_reg <= hi_reg + 4'h1;
                        state_reg <= last_hi ? S_IDLE : S_CORR;
                        run_done <= last_hi;
                    end
                end
            endcase
        end
    end

    wch_skid_buf #(
        .WIDTH(`WCH_RES_W)
    ) u_res_buf (
        .clk(clk),
        .rstn(rstn),
        .in_valid(push_valid_reg),
        .in_data(push_data_reg),
        .in_ready(push_ready),
        .out_valid(res_valid),
        .out_data(res_data),
        .out_ready(res_ready)
    );
endmodule // wch_analyzer

// *** core/wch_map.vh ***
`ifndef WCH_MAP_VH
`define WCH_MAP_VH

// ------------------------------------------------------------
// Sample format and buffers
// ------------------------------------------------------------
`define WCH_SAMPLE_W 13
`define WCH_DISP_LEN 100
`define WCH_ANA_LEN 1024
`define WCH_SAMPLE_RATE 4096

// ------------------------------------------------------------
// Channel map
// ------------------------------------------------------------
`define WCH_NUM_CH 18
`define WCH_CH_MAINS_I_FIRST 5'h06
`define WCH_CH_MAINS_I_LAST 5'h08
`define WCH_CH_GEN_V_FIRST 5'h09
`define WCH_CH_LAST 5'h11

// ------------------------------------------------------------
// Timing: refreshes per second, refresh period counted in sample ticks
// ------------------------------------------------------------
`define WCH_REFRESH_PER_SEC 2
`define WCH_REFRESH_TICKS (`WCH_SAMPLE_RATE / `WCH_REFRESH_PER_SEC)

// ------------------------------------------------------------
// Harmonic limits; levels are in tenths of a percent
// ------------------------------------------------------------
`define WCH_MAX_HARM_HZ 1800
`define WCH_MAX_ORDER 31
`define WCH_NUM_ODD 16
`define WCH_PCT_SCALE 1000
`define WCH_PCT_MAX 10'h3ff
`define WCH_GRAPH_MIN 20

// ------------------------------------------------------------
// Result word: channel, order, graph flag, level
// ------------------------------------------------------------
`define WCH_RES_W 21
`define WCH_RES_CH_LSB 16
`define WCH_RES_ORD_LSB 11
`define WCH_RES_GFX_BIT 10

`endif

// *** core/wch_skid_buf.v ***
`timescale 1ns/1ps

// ------------------------------------------------------------
// Two-entry buffer: output register plus skid register
// ------------------------------------------------------------
module wch_skid_buf #(
    parameter WIDTH = 21
) (
    clk,
    rstn,
    in_valid,
    in_data,
    in_ready,
    out_valid,
    out_data,
    out_ready
);
    input wire clk;
    input wire rstn;
    input wire in_valid;
    input wire [WIDTH-1:0] in_data;
    output reg in_ready;
    output reg out_valid;
    output reg [WIDTH-1:0] out_data;
    input wire out_ready;

    reg skid_valid_reg;
    reg [WIDTH-1:0] skid_data_reg;
    wire push;
    wire pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
            skid_valid_reg <= 1'b0;
            skid_data_reg <= {WIDTH{1'b0}};
            in_ready <= 1'b1;
        end else begin
            if (!out_valid || pop) begin
                if (skid_valid_reg) begin
                    out_valid <= 1'b1;
                    out_data <= skid_data_reg;
                    skid_valid_reg <= push;
                    skid_data_reg <= in_data;
                    in_ready <= !push;
                end else begin
                    out_valid <= push;
                    out_data <= push ? in_data : out_data;
                    in_ready <= 1'b1;
                end
            end else if (push) begin
                // Receiver stalled: park the word so nothing is lost
                skid_valid_reg <= 1'b1;
                skid_data_reg <= in_data;
                in_ready <= 1'b0;
            end
        end
    end
endmodule // wch_skid_buf

// *** verif/wch_analyzer_assertions.sv ***
`timescale 1ns/1ps
module wch_analyzer_chk #(
    parameter SW = 13
) (
    input wire clk,
    input wire rstn,
    input wire [11:0] fund_hz,
    input wire ct_load_side_pin,
    input wire [6:0] disp_rd_addr,
    input wire [SW-1:0] disp_rd_data,
    input wire [3:0] disp_scale,
    input wire [4:0] sel_ch,
    input wire run_done,
    input wire res_valid,
    input wire [20:0] res_data,
    input wire res_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire [4:0] ord = res_data[15:11];
    reg [4:0] last_ord_reg;
    // ------------------------------------------------------------
    // Last accepted order, for the ascending check
    // ------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            last_ord_reg <= 5'h00;
        else if (res_valid && res_ready)
            last_ord_reg <= ord;
    end
    sequence s_stall;
        res_valid && !res_ready;
    endsequence
    sequence s_ct_low;
        (!ct_load_side_pin) [*5];
    endsequence
    chk_sel_range: assert property (sel_ch <= 5'h11)
        else $error("selected channel out of range");
    chk_ct_skip: assert property (s_ct_low |-> !(sel_ch >= 5'h06 && sel_ch <= 5'h08))
        else $error("mains current channel selected without load side sensing");
    chk_sel_step: assert property ($changed(sel_ch) |-> sel_ch == 5'h09 ||
        sel_ch == (($past(sel_ch) == 5'h11) ? 5'h00 : $past(sel_ch) + 5'h01))
        else $error("channel selection did not step by one");
    chk_stall_hold: assert property (s_stall |=> res_valid && $stable(res_data))
        else $error("result word lost or changed while stalled");
    chk_odd_order: assert property (res_valid |-> ord[0] && ord >= 5'h03)
        else $error("even or fundamental order reported");
    chk_freq_limit: assert property (res_valid |-> 32'(ord) * 32'(fund_hz) <= 1800)
        else $error("harmonic above frequency limit reported");
    chk_order_seq: assert property (res_valid |-> ord == 5'h03 || ord == last_ord_reg + 5'h02)
        else $error("harmonic order skipped or out of sequence");
    chk_graph_flag: assert property (res_valid |-> res_data[10] == (res_data[9:0] > 10'h014))
        else $error("graph flag disagrees with level");
    chk_done_pulse: assert property (run_done |=> !run_done)
        else $error("run done longer than one cycle");
    chk_rd_blank: assert property (disp_rd_addr >= 7'h64 |=> disp_rd_data == '0)
        else $error("read beyond display buffer not zero");
    chk_scale_max: assert property (disp_scale <= 4'hd)
        else $error("display scale wider than sample");
endmodule // wch_analyzer_chk

bind wch_analyzer wch_analyzer_chk #(.SW(SW)) u_chk (.clk(clk), .rstn(rstn), .fund_hz(fund_hz),
    .ct_load_side_pin(ct_load_side_pin), .disp_rd_addr(disp_rd_addr),
    .disp_rd_data(disp_rd_data), .disp_scale(disp_scale), .sel_ch(sel_ch),
    .run_done(run_done), .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready));

// *** verif/wch_front_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Sampling front end: square waves, amplitude set per channel
// ------------------------------------------------------------
module wch_front_model #(
    parameter SW = 13
) (
    input wire clk,
    input wire rstn,
    input wire run,
    input wire [11:0] fund_hz,
    output reg sample_tick,
    output wire [18*SW-1:0] samples_bus
);
    reg [11:0] phase_reg;
    reg [18*SW-1:0] value;
    integer c;
    // Ticks every other clock so a refresh period stays short
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sample_tick <= 1'b0;
            phase_reg <= 12'h000;
        end else begin
            sample_tick <= run && !sample_tick;
            if (sample_tick)
                phase_reg <= phase_reg + fund_hz;
        end
    end
    always @* begin
        for (c = 0; c < 18; c = c + 1)
            value[c*SW +: SW] = phase_reg[11] ? -((c + 1) * 64) : (c + 1) * 64;
    end
    // Between ticks the bus carries garbage, not the last sample
    assign samples_bus = sample_tick ? value : ~value;
endmodule // wch_front_model

// *** verif/tb_wch_analyzer.sv ***
`timescale 1ns/1ps
module tb_wch_analyzer;
    reg clk, rstn, run, btn_next_pin, ct_load_side_pin, res_ready;
    reg [11:0] fund_hz;
    reg [6:0] disp_rd_addr;
    wire sample_tick, run_done, res_valid;
    wire [233:0] samples_bus;
    wire [12:0] disp_rd_data;
    wire [3:0] disp_scale;
    wire [4:0] sel_ch;
    wire [20:0] res_data;
    integer fail_count, comparisons, i;
    reg [4:0] exp_ch;

    wch_front_model #(.SW(13)) partner (.clk(clk), .rstn(rstn), .run(run), .fund_hz(fund_hz),
        .sample_tick(sample_tick), .samples_bus(samples_bus));
    wch_analyzer #(.SW(13)) dut (.clk(clk), .rstn(rstn), .sample_tick(sample_tick),
        .samples_bus(samples_bus), .fund_hz(fund_hz), .btn_next_pin(btn_next_pin),
        .ct_load_side_pin(ct_load_side_pin), .disp_rd_addr(disp_rd_addr),
        .disp_rd_data(disp_rd_data), .disp_scale(disp_scale), .sel_ch(sel_ch),
        .run_done(run_done), .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task check(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, fail_count);
            if (fail_count == 0 && comparisons > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    function [4:0] next_ch(input [4:0] c);
        begin
            next_ch = (c == 5'h11) ? 5'h00 : c + 5'h01;
            if (!ct_load_side_pin && next_ch >= 5'h06 && next_ch <= 5'h08)
                next_ch = 5'h09;
        end
    endfunction
    // Held four cycles: the pin passes a two-flop synchroniser
    task press;
        begin
            btn_next_pin = 1'b1;
            repeat (4) @(negedge clk);
            btn_next_pin = 1'b0;
            repeat (4) @(negedge clk);
            exp_ch = next_ch(exp_ch);
            check(sel_ch, exp_ch);
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task test_buttons;
        begin
            ct_load_side_pin = 1'b1;
            for (i = 0; i < 25; i = i + 1) press;
            ct_load_side_pin = 1'b0;
            repeat (6) @(negedge clk);
            exp_ch = 5'h09;
            check(sel_ch, exp_ch);
            for (i = 0; i < 15; i = i + 1) press;
            $display("test_buttons done");
        end
    endtask
    task run_capture(input [11:0] f, input [4:0] ch, input integer stall);
        integer t, held, left, nexp, ex;
        reg [4:0] ord;
        begin
            fund_hz = f;
            run = 1'b1;
            held = 0;
            left = -1;
            ord = 5'h03;
            nexp = 0;
            for (t = 3; t <= 31; t = t + 2)
                if (t * f <= 1800) nexp = nexp + 1;
            for (t = 0; t < 60000 && left != 0; t = t + 1) begin
                @(negedge clk);
                // Ready first: it decides whether the standing word goes at the next edge
                if (res_valid === 1'b1) held = held + 1;
                res_ready = !(stall != 0 && held < 2000);
                if (res_valid === 1'b1 && res_ready) begin
                    ex = 1000 / ord;
                    check(res_data[20:16], ch);
                    check(res_data[15:11], ord);
                    check(res_data[10], 1);
                    check(res_data[9:0] * 10 >= ex * 7 && res_data[9:0] * 10 <= ex * 13, 1);
                    ord = ord + 5'h02;
                end
                if (run_done === 1'b1) left = 40;
                if (left > 0) left = left - 1;
            end
            run = 1'b0;
            if (left != 0) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t got %h exp %h", $time, left, 0);
                test_done;
            end
            check((ord - 5'h03) / 2, nexp);
            $display("run_capture done at %0d Hz", f);
        end
    endtask
    task check_display(input [4:0] ch);
        reg [12:0] a;
        integer n;
        begin
            a = (ch + 1) * 64;
            n = 0;
            while ((a >> n) != 0) n = n + 1;
            check(disp_scale, n);
            for (i = 0; i < 101; i = i + 1) begin
                disp_rd_addr = i[6:0];
                repeat (2) @(negedge clk);
                if (i < 100) check(disp_rd_data === a || disp_rd_data === -a, 1);
                else check(disp_rd_data, 0);
            end
            $display("check_display done");
        end
    endtask
    initial begin
        rstn = 1'b0;
        run = 1'b0;
        btn_next_pin = 1'b0;
        ct_load_side_pin = 1'b1;
        res_ready = 1'b1;
        fund_hz = 12'h000;
        disp_rd_addr = 7'h00;
        fail_count = 0;
        comparisons = 0;
        exp_ch = 5'h00;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        check(sel_ch, 0);
        check(res_valid, 0);
        test_buttons;
        run_capture(12'h190, 5'h09, 0);
        check_display(5'h09);
        for (i = 0; i < 6; i = i + 1) press;
        run_capture(12'h03c, 5'h0f, 1);
        test_done;
    end
endmodule // tb_wch_analyzer
